// ===== logic/sensor_seq_pkg.sv
/*
  Shared constants for the sensor power, boot and streaming sequencers:
  clock rate, sequence times and their cycle counts, frame geometry.
  Assumes a single 250 MHz core clock on both ends of the link.
*/
package sensor_seq_pkg;

  // core clock rate
  localparam int CORE_CLK_MHZ = 250;

  // supplies stable to reset release, least time
  localparam real SUPPLY_SETTLE_MS = 1.0;
  localparam int SUPPLY_SETTLE_CYCLES =
    int'($ceil(SUPPLY_SETTLE_MS * 1000.0 * CORE_CLK_MHZ));

  // pll lock: the sensor locks within this, the host waits at least it
  localparam real PLL_LOCK_MS = 1.0;
  localparam int PLL_LOCK_MAX_CYCLES =
    int'($floor(PLL_LOCK_MS * 1000.0 * CORE_CLK_MHZ));
  localparam int PLL_LOCK_WAIT_CYCLES =
    int'($ceil(PLL_LOCK_MS * 1000.0 * CORE_CLK_MHZ));

  // one-time memory load, in external input clock cycles
  localparam int BOOT_LOAD_EDGES = 160000;

  // width of every sequence counter
  localparam int TIMER_W = 20;

  // external input clock divider and serial lane count
  localparam int EXT_CLK_DIV = 4;
  localparam int LANE_MAX = 4;

  // frame geometry of the streaming model, in core cycles and lines
  localparam int LINE_ACTIVE = 16;
  localparam int LINE_TOTAL = 20;
  localparam int FRAME_ACTIVE = 8;
  localparam int FRAME_TOTAL = 10;

  // geometry counter widths
  localparam int PIX_W = 12;
  localparam int LINE_W = 12;

endpackage

// ===== logic/sensor_link_if.sv
/*
  Link between the host sequencer and the sensor sequencer: reset pin,
  external input clock and a minimal stream-control write channel.
  Assumes both ends share core_clk; the external clock is a plain level.
*/
`timescale 1ns/10ps
interface sensor_link_if;
  logic reset_n;
  logic external_input_clock;
  logic ctrl_wr;
  logic ctrl_stream_on;
  logic ctrl_line_stop;
  logic ctrl_ack;
  logic ctrl_err;
  logic stream_active;

  // host end drives pins and writes
  modport host
  (
    output reset_n,
    output external_input_clock,
    output ctrl_wr,
    output ctrl_stream_on,
    output ctrl_line_stop,
    input ctrl_ack,
    input ctrl_err,
    input stream_active
  );

  // sensor end answers writes and reports streaming
  modport sensor
  (
    input reset_n,
    input external_input_clock,
    input ctrl_wr,
    input ctrl_stream_on,
    input ctrl_line_stop,
    output ctrl_ack,
    output ctrl_err,
    output stream_active
  );
endinterface

// ===== logic/cycle_timer.sv
/*
  Down counter that finishes after a loaded number of ticks.
  Assumes start and tick are synchronous to core_clk; idle reads done.
*/
`timescale 1ns/10ps
module cycle_timer
#(
  parameter int WIDTH = 20
)
(
  // clock and control
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // load and count
  input wire logic start,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic tick,
  // result
  output logic done
);
  logic [WIDTH-1:0] count_r;
  logic done_r;

  // start wins over tick, so a restart is never missed
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      count_r <= '0;
      done_r <= 1'b1;
    end
    else if (ce)
    begin
      if (start)
      begin
        count_r <= load_value;
        done_r <= (load_value == '0);
      end
      else if (!done_r && tick)
      begin
        count_r <= count_r - 1'b1;
        done_r <= (count_r == WIDTH'(1));
      end
    end
  end

  assign done = done_r;
endmodule

// ===== logic/sensor_sequencer.sv
/*
  Sensor end of the link: hard standby while the reset pin is low,
  one-time memory load counted on external input clock edges, pll lock,
  streaming and a stop that ends on a frame or line boundary.
  Assumes the link pins are synchronous to core_clk.
*/
`timescale 1ns/10ps
module sensor_sequencer
#(
  parameter int BOOT_EDGES = sensor_seq_pkg::BOOT_LOAD_EDGES,
  parameter int LOCK_CYCLES = sensor_seq_pkg::PLL_LOCK_MAX_CYCLES,
  parameter int LANE_COUNT = sensor_seq_pkg::LANE_MAX,
  parameter int LINE_ACTIVE = sensor_seq_pkg::LINE_ACTIVE,
  parameter int LINE_TOTAL = sensor_seq_pkg::LINE_TOTAL,
  parameter int FRAME_ACTIVE = sensor_seq_pkg::FRAME_ACTIVE,
  parameter int FRAME_TOTAL = sensor_seq_pkg::FRAME_TOTAL
)
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // link to the host
  sensor_link_if.sensor link,
  // status toward the user
  output logic hard_standby,
  output logic boot_busy,
  output logic pll_locking,
  output logic streaming,
  // image timing toward the lanes
  output logic frame_valid,
  output logic line_valid,
  output logic [sensor_seq_pkg::LANE_MAX-1:0] lane_active
);
  typedef enum logic [2:0]
  {
    HARD_STANDBY,
    BOOT_LOAD,
    SOFT_STANDBY,
    PLL_LOCK,
    STREAMING,
    STOPPING
  } sensor_state_type;

  localparam int TW = sensor_seq_pkg::TIMER_W;
  localparam int PW = sensor_seq_pkg::PIX_W;
  localparam int LW = sensor_seq_pkg::LINE_W;

  sensor_state_type state_r;
  sensor_state_type state_nxt;
  logic ext_clk_prev_r;
  logic ext_rise;
  logic timer_start;
  logic [TW-1:0] timer_load;
  logic timer_tick;
  logic timer_done;
  logic wr_ok;
  logic wr_on;
  logic wr_off;
  logic stop_line_r;
  logic [PW-1:0] pix_r;
  logic [LW-1:0] line_r;
  logic line_end;
  logic frame_end;
  logic boundary;
  logic video_on;
  logic ack_r;
  logic err_r;
  logic stream_active_r;
  logic hard_standby_r;
  logic boot_busy_r;
  logic pll_locking_r;
  logic streaming_r;
  logic frame_valid_r;
  logic line_valid_r;
  logic [sensor_seq_pkg::LANE_MAX-1:0] lane_active_r;

  // true while the state carries video timing
  function automatic logic is_video(sensor_state_type s);
    return (s == STREAMING) || (s == STOPPING);
  endfunction

  // input clock edges; a stopped clock just stalls the load
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ext_clk_prev_r <= 1'b0;
    else if (ce)
      ext_clk_prev_r <= link.external_input_clock;
  end

  assign ext_rise = link.external_input_clock && !ext_clk_prev_r;

  // writes are only acknowledged once the memory load has finished; earlier ones get ctrl_err
  assign wr_ok = (state_r != HARD_STANDBY) && (state_r != BOOT_LOAD);
  assign wr_on = link.ctrl_wr && wr_ok && link.ctrl_stream_on;
  assign wr_off = link.ctrl_wr && wr_ok && !link.ctrl_stream_on;

  // boundaries of the running frame
  assign line_end = (pix_r == PW'(LINE_TOTAL - 1));
  assign frame_end = line_end && (line_r == LW'(FRAME_TOTAL - 1));
  assign boundary = stop_line_r ? line_end : frame_end;
  assign video_on = is_video(state_r);

  // next state; reset pin handling sits in the state register
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      HARD_STANDBY:
        state_nxt = BOOT_LOAD;
      BOOT_LOAD:
        if (timer_done)
          state_nxt = SOFT_STANDBY;
      SOFT_STANDBY:
        if (wr_on)
          state_nxt = PLL_LOCK;
      PLL_LOCK:
        if (wr_off)
          state_nxt = SOFT_STANDBY;
        else if (timer_done)
          state_nxt = STREAMING;
      STREAMING:
        if (wr_off)
          state_nxt = STOPPING;
      STOPPING:
        if (wr_on)
          state_nxt = STREAMING;
        else if (boundary)
          state_nxt = SOFT_STANDBY;
      default:
        state_nxt = HARD_STANDBY;
    endcase
  end

  // state register; a low reset pin overrides everything
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_r <= HARD_STANDBY;
    else if (ce)
    begin
      if (!link.reset_n)
        state_r <= HARD_STANDBY;
      else
        state_r <= state_nxt;
    end
  end

  // one timer serves both the load and the lock wait
  assign timer_start = link.reset_n &&
                       (state_r != state_nxt) &&
                       ((state_nxt == BOOT_LOAD) || (state_nxt == PLL_LOCK));
  assign timer_load = (state_nxt == BOOT_LOAD) ? TW'(BOOT_EDGES)
                                               : TW'(LOCK_CYCLES);
  assign timer_tick = (state_r == BOOT_LOAD) ? ext_rise : 1'b1;

  cycle_timer
  #(
    .WIDTH(TW)
  )
  seq_timer
  (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .start(timer_start),
    .load_value(timer_load),
    .tick(timer_tick),
    .done(timer_done)
  );

  // stop mode is latched with the standby write
  always_ff @(posedge core_clk)
  begin
    if (reset)
      stop_line_r <= 1'b0;
    else if (ce && wr_off)
      stop_line_r <= link.ctrl_line_stop;
  end

  // pixel and line counters restart with every stream start out of PLL_LOCK; a resume from STOPPING keeps counting
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pix_r <= '0;
      line_r <= '0;
    end
    else if (ce)
    begin
      if (!video_on || !link.reset_n)
      begin
        pix_r <= '0;
        line_r <= '0;
      end
      else if (line_end)
      begin
        pix_r <= '0;
        line_r <= frame_end ? '0 : line_r + 1'b1;
      end
      else
        pix_r <= pix_r + 1'b1;
    end
  end

  // write answers, one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else if (ce)
    begin
      ack_r <= link.ctrl_wr && wr_ok;
      err_r <= link.ctrl_wr && !wr_ok;
    end
  end

  // status flags follow the next state, hard_standby the reset pin, so they match the answers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stream_active_r <= 1'b0;
      hard_standby_r <= 1'b1;
      boot_busy_r <= 1'b0;
      pll_locking_r <= 1'b0;
      streaming_r <= 1'b0;
    end
    else if (ce)
    begin
      stream_active_r <= link.reset_n && is_video(state_nxt);
      hard_standby_r <= !link.reset_n;
      boot_busy_r <= link.reset_n && (state_nxt == BOOT_LOAD);
      pll_locking_r <= link.reset_n && (state_nxt == PLL_LOCK);
      streaming_r <= link.reset_n && (state_nxt == STREAMING);
    end
  end

  // image timing; lanes idle outside the STREAMING and STOPPING states
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      frame_valid_r <= 1'b0;
      line_valid_r <= 1'b0;
      lane_active_r <= '0;
    end
    else if (ce)
    begin
      frame_valid_r <= video_on && (line_r < LW'(FRAME_ACTIVE));
      line_valid_r <= video_on && (line_r < LW'(FRAME_ACTIVE)) &&
                      (pix_r < PW'(LINE_ACTIVE));
      lane_active_r <= video_on
        ? sensor_seq_pkg::LANE_MAX'((1 << LANE_COUNT) - 1)
        : '0;
    end
  end

  assign link.ctrl_ack = ack_r;
  assign link.ctrl_err = err_r;
  assign link.stream_active = stream_active_r;
  assign hard_standby = hard_standby_r;
  assign boot_busy = boot_busy_r;
  assign pll_locking = pll_locking_r;
  assign streaming = streaming_r;
  assign frame_valid = frame_valid_r;
  assign line_valid = line_valid_r;
  assign lane_active = lane_active_r;
endmodule

// ===== logic/host_sequencer.sv
/*
  Host end of the link: supply enable, reset pin, divided external input
  clock, and the stream-control writes in the order the sensor needs.
  Assumes supplies_stable is synchronous and reports all rails good.
*/
`timescale 1ns/10ps
module host_sequencer
#(
  parameter int SETTLE_CYCLES = sensor_seq_pkg::SUPPLY_SETTLE_CYCLES,
  parameter int BOOT_EDGES = sensor_seq_pkg::BOOT_LOAD_EDGES,
  parameter int LOCK_CYCLES = sensor_seq_pkg::PLL_LOCK_WAIT_CYCLES,
  parameter int CLK_DIV = sensor_seq_pkg::EXT_CLK_DIV
)
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // user requests
  input wire logic power_req,
  input wire logic stream_req,
  input wire logic line_stop_cfg,
  // supplies
  input wire logic supplies_stable,
  output logic supply_en,
  // status
  output logic sensor_ready,
  output logic stream_expected,
  output logic ctrl_fault,
  // link to the sensor
  sensor_link_if.host link
);
  typedef enum logic [3:0]
  {
    OFF,
    SUPPLY_RAMP,
    SETTLE,
    BOOT_WAIT,
    READY,
    SEND_ON,
    LOCK_WAIT,
    STREAM,
    SEND_OFF,
    DRAIN,
    HOLD_RESET
  } host_state_type;

  localparam int TW = sensor_seq_pkg::TIMER_W;
  localparam int DW = sensor_seq_pkg::TIMER_W;

  host_state_type state_r;
  host_state_type state_nxt;
  logic [DW-1:0] div_r;
  logic ext_rise;
  logic want_off;
  logic timer_start;
  logic [TW-1:0] timer_load;
  logic timer_done;
  logic supply_en_r;
  logic reset_n_r;
  logic ext_clk_r;
  logic wr_r;
  logic stream_on_r;
  logic line_stop_r;
  logic ready_r;
  logic expected_r;
  logic fault_r;

  // free-running input clock, present through the whole sequence
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_r <= '0;
      ext_clk_r <= 1'b0;
    end
    else if (ce)
    begin
      div_r <= (div_r == DW'(CLK_DIV - 1)) ? '0 : div_r + 1'b1;
      ext_clk_r <= (div_r == DW'(CLK_DIV - 1));
    end
  end

  // counts the same rising edges the sensor sees
  assign ext_rise = (div_r == DW'(CLK_DIV - 1));
  assign want_off = !stream_req || !power_req;

  // sequence: supplies, settle, boot, stream, stop, reset, supplies off
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      OFF:
        if (power_req)
          state_nxt = SUPPLY_RAMP;
      SUPPLY_RAMP:
        if (supplies_stable)
          state_nxt = SETTLE;
      SETTLE:
        if (timer_done)
          state_nxt = BOOT_WAIT;
      BOOT_WAIT:
        if (timer_done)
          state_nxt = READY;
      READY:
        if (!power_req)
          state_nxt = HOLD_RESET;
        else if (stream_req)
          state_nxt = SEND_ON;
      SEND_ON:
        if (link.ctrl_ack)
          state_nxt = LOCK_WAIT;
        else if (link.ctrl_err)
          state_nxt = READY;
      LOCK_WAIT:
        if (want_off)
          state_nxt = SEND_OFF;
        else if (timer_done)
          state_nxt = STREAM;
      STREAM:
        if (want_off)
          state_nxt = SEND_OFF;
      SEND_OFF:
        if (link.ctrl_ack || link.ctrl_err)
          state_nxt = DRAIN;
      DRAIN:
        if (!link.stream_active)
          state_nxt = READY;
      HOLD_RESET:
        state_nxt = OFF;
      default:
        state_nxt = OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_r <= OFF;
    else if (ce)
      state_r <= state_nxt;
  end

  // one timer for settle, boot load and lock wait
  assign timer_start = (state_r != state_nxt) &&
                       ((state_nxt == SETTLE) || (state_nxt == BOOT_WAIT) ||
                        (state_nxt == LOCK_WAIT));
  always_comb
  begin
    unique case (state_nxt)
      SETTLE:
        timer_load = TW'(SETTLE_CYCLES);
      BOOT_WAIT:
        timer_load = TW'(BOOT_EDGES);
      default:
        timer_load = TW'(LOCK_CYCLES);
    endcase
  end

  cycle_timer
  #(
    .WIDTH(TW)
  )
  seq_timer
  (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .start(timer_start),
    .load_value(timer_load),
    .tick((state_r == BOOT_WAIT) ? ext_rise : 1'b1),
    .done(timer_done)
  );

  // pins and writes; a write strobe lasts one cycle on state entry
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      supply_en_r <= 1'b0;
      reset_n_r <= 1'b0;
      wr_r <= 1'b0;
      stream_on_r <= 1'b0;
      line_stop_r <= 1'b0;
    end
    else if (ce)
    begin
      supply_en_r <= (state_nxt != OFF);
      reset_n_r <= (state_nxt != OFF) && (state_nxt != SUPPLY_RAMP) &&
                   (state_nxt != SETTLE) && (state_nxt != HOLD_RESET);
      wr_r <= (state_r != state_nxt) &&
              ((state_nxt == SEND_ON) || (state_nxt == SEND_OFF));
      stream_on_r <= (state_nxt == SEND_ON);
      line_stop_r <= line_stop_cfg;
    end
  end

  // status; the fault flag holds until power is dropped
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ready_r <= 1'b0;
      expected_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else if (ce)
    begin
      ready_r <= (state_nxt == READY);
      expected_r <= (state_nxt == STREAM);
      if (link.ctrl_err)
        fault_r <= 1'b1;
      else if (state_r == OFF)
        fault_r <= 1'b0;
    end
  end

  assign supply_en = supply_en_r;
  assign sensor_ready = ready_r;
  assign stream_expected = expected_r;
  assign ctrl_fault = fault_r;
  assign link.reset_n = reset_n_r;
  assign link.external_input_clock = ext_clk_r;
  assign link.ctrl_wr = wr_r;
  assign link.ctrl_stream_on = stream_on_r;
  assign link.ctrl_line_stop = line_stop_r;
endmodule

// ===== dv/link_asserts.sv
/*
  Concurrent checks on the link between host and sensor sequencers.
  Assumes ce drops only while the link idles; sees only the link signals.
*/
`timescale 1ns/10ps
module link_asserts
#(
  parameter int SETTLE_CYCLES = 20,
  parameter int BOOT_EDGES = 10,
  parameter int LOCK_CYCLES = 15
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link signals
  input wire logic reset_n,
  input wire logic external_input_clock,
  input wire logic ctrl_wr,
  input wire logic ctrl_stream_on,
  input wire logic ctrl_ack,
  input wire logic ctrl_err,
  input wire logic stream_active
);
  localparam int LOCK_HI = LOCK_CYCLES + 4;
  logic [7:0] edge_cnt_r;
  logic [15:0] low_cnt_r;
  logic ext_prev_r;
  logic off_seen_r;

  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // input clock rising edges since the reset pin went high
  always_ff @(posedge core_clk)
  begin
    ext_prev_r <= external_input_clock;
    if (reset || !reset_n)
      edge_cnt_r <= 8'h00;
    else if (external_input_clock && !ext_prev_r && edge_cnt_r != 8'hFF)
      edge_cnt_r <= edge_cnt_r + 8'h01;
  end

  // cycles the reset pin has been low, saturating
  always_ff @(posedge core_clk)
  begin
    if (reset || reset_n)
      low_cnt_r <= 16'h0000;
    else if (low_cnt_r != 16'hFFFF)
      low_cnt_r <= low_cnt_r + 16'h0001;
  end

  // last write was a stop; a drop without one is illegal
  always_ff @(posedge core_clk)
  begin
    if (reset)
      off_seen_r <= 1'b0;
    else if (ctrl_wr)
      off_seen_r <= !ctrl_stream_on;
  end

  a_write_answered: assert property (
    ctrl_wr |=> ctrl_ack && !ctrl_err)
    else $error("link write not acknowledged next cycle");
  a_no_stray_answer: assert property (
    !ctrl_wr |=> !ctrl_ack && !ctrl_err)
    else $error("answer without a write");
  a_write_spacing: assert property (
    ctrl_wr |=> !ctrl_wr)
    else $error("writes closer than two cycles");
  a_boot_wait_done: assert property (
    ctrl_wr |-> int'(edge_cnt_r) >= BOOT_EDGES)
    else $error("write before boot load clock count");
  a_settle_before_release: assert property (
    $rose(reset_n) |-> int'(low_cnt_r) >= SETTLE_CYCLES)
    else $error("reset pin released too early");
  a_lock_then_stream: assert property (
    ctrl_wr && ctrl_stream_on && !stream_active ##1 ctrl_ack
    |=> !stream_active [*8] ##[1:LOCK_HI] stream_active)
    else $error("streaming not after pll lock time");
  a_stop_bounded: assert property (
    ctrl_wr && !ctrl_stream_on && stream_active
    |-> ##[1:260] !stream_active)
    else $error("stop did not finish within one frame");
  a_standby_quiet: assert property (
    !reset_n [*2] |-> !stream_active)
    else $error("streaming while reset pin low");
  a_reset_after_stop: assert property (
    $fell(reset_n) |-> !stream_active)
    else $error("reset pin lowered while streaming");
  a_drop_needs_stop: assert property (
    $fell(stream_active) |-> off_seen_r)
    else $error("streaming ended without a stop write");
endmodule

// ===== dv/testbench.sv
/*
  Bench joining host and sensor sequencers over the link interface.
  Assumes shortened counts; ce is dropped once, only while the link idles.
*/
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic power_req = 1'b0;
  logic stream_req = 1'b0;
  logic line_stop_cfg = 1'b0;
  logic supplies_stable = 1'b0;
  logic supply_en, sensor_ready, stream_expected, ctrl_fault;
  logic hard_standby, boot_busy, pll_locking, streaming;
  logic frame_valid, line_valid;
  logic [sensor_seq_pkg::LANE_MAX-1:0] lane_active;
  logic rst_p = 1'b1;
  logic rdy_p, str_p, sa_p, rn_p, fv_p, on_p, ls_p;
  logic rdy_q, str_q;
  logic ce = 1'b1;
  logic [7:0] lv_cnt = 8'h00;
  logic [7:0] notes[$];
  logic [31:0] seed = 32'h7;
  int lock_cnt = 0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  sensor_link_if link();

  // input clock divider left at its default
  host_sequencer #(.SETTLE_CYCLES(20), .BOOT_EDGES(10),
    .LOCK_CYCLES(15)) u_host_sequencer
  (
    .core_clk(core_clk), .reset(reset), .ce(ce),
    .power_req(power_req), .stream_req(stream_req),
    .line_stop_cfg(line_stop_cfg), .supplies_stable(supplies_stable),
    .supply_en(supply_en), .sensor_ready(sensor_ready),
    .stream_expected(stream_expected), .ctrl_fault(ctrl_fault),
    .link(link)
  );

  sensor_sequencer #(.BOOT_EDGES(10), .LOCK_CYCLES(15)) u_sensor_sequencer
  (
    .core_clk(core_clk), .reset(reset), .ce(ce), .link(link),
    .hard_standby(hard_standby), .boot_busy(boot_busy),
    .pll_locking(pll_locking), .streaming(streaming),
    .frame_valid(frame_valid), .line_valid(line_valid),
    .lane_active(lane_active)
  );

  // checker defaults already match the shortened counts
  link_asserts u_link_asserts
  (
    .core_clk(core_clk), .reset(reset), .reset_n(link.reset_n),
    .external_input_clock(link.external_input_clock),
    .ctrl_wr(link.ctrl_wr), .ctrl_stream_on(link.ctrl_stream_on),
    .ctrl_ack(link.ctrl_ack), .ctrl_err(link.ctrl_err),
    .stream_active(link.stream_active)
  );

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // an event with no note left is compared against unknown and fails
  task automatic take(input string name, input logic [7:0] seen);
    check(name, seen, notes.size() > 0 ? notes.pop_front() : 8'hXX);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // rails come good half a cycle after enable, on the next falling edge
  always @(negedge core_clk)
    supplies_stable <= supply_en;

  // hang guard, well above the longest sequence
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  // watch outputs on falling edges, where they have settled
  always @(negedge core_clk)
  begin
    if (rst_p && !reset)
      take("reset", {3'h0, hard_standby, streaming, link.stream_active,
        supply_en, link.reset_n});
    else if (!reset)
    begin
      // one edge late: the sensor ends its load an edge after the host
      if (rdy_p && !rdy_q)
        take("ready", {4'h0, ctrl_fault, pll_locking, hard_standby,
          boot_busy});
      // lanes follow the state register, an edge behind streaming
      if (str_p && !str_q)
        take("stream", {lane_active, 3'h0, lock_cnt >= 14});
      if (!link.stream_active && sa_p)
        take("stop", ls_p ? lv_cnt % 8'h10 : lv_cnt);
      if (!link.reset_n && rn_p)
        take("power", {6'h00, supply_en, link.stream_active});
    end
    if (link.ctrl_wr)
      on_p <= link.ctrl_stream_on;
    if (link.ctrl_wr && !link.ctrl_stream_on)
      ls_p <= link.ctrl_line_stop;
    lock_cnt <= (link.ctrl_ack && on_p) ? 0 : lock_cnt + 1;
    // video cycles since frame start; a cut line or frame shows here
    lv_cnt <= (frame_valid && !fv_p) ? 8'(line_valid)
      : lv_cnt + 8'(line_valid);
    rst_p <= reset;
    rdy_p <= sensor_ready;
    rdy_q <= rdy_p;
    str_p <= streaming;
    str_q <= str_p;
    sa_p <= link.stream_active;
    rn_p <= link.reset_n;
    fv_p <= frame_valid;
  end

  // power up, stream and stop in both modes, power down, reset mid-run
  initial
  begin
    notes.push_back(8'h10);
    cyc(2);
    // nonblocking, so the watcher on this edge still sees reset high
    reset <= 1'b0;
    cyc(1);
    power_req = 1'b1;
    notes.push_back(8'h00);
    wait (sensor_ready === 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      cyc(3);
      line_stop_cfg = i[0];
      // a held-low enable must keep the host from writing
      if (i == 0)
      begin
        ce = 1'b0;
        stream_req = 1'b1;
        cyc(4);
        check("freeze", {6'h00, sensor_ready, link.ctrl_wr}, 8'h02);
        ce = 1'b1;
      end
      stream_req = 1'b1;
      notes.push_back(8'hF1);
      wait (stream_expected === 1'b1);
      seed = next_rand(seed);
      cyc(int'(seed[7:0]) + 1);
      notes.push_back(i[0] ? 8'h00 : 8'h80);
      notes.push_back(8'h00);
      stream_req = 1'b0;
      cyc(2);
      wait (sensor_ready === 1'b1);
    end
    cyc(3);
    notes.push_back(8'h02);
    power_req = 1'b0;
    wait (supply_en === 1'b0);
    cyc(3);
    power_req = 1'b1;
    notes.push_back(8'h00);
    wait (sensor_ready === 1'b1);
    cyc(2);
    stream_req = 1'b1;
    notes.push_back(8'hF1);
    wait (stream_expected === 1'b1);
    cyc(5);
    notes.push_back(8'h10);
    reset <= 1'b1;
    power_req = 1'b0;
    stream_req = 1'b0;
    cyc(2);
    reset <= 1'b0;
    cyc(20);
    check("notes", 8'(notes.size()), 8'h00);
    stop_test();
  end
endmodule
